// ==== shared/crp_pkg.sv ====
`default_nettype none
package crp_pkg;
   // Interface register offsets in the coprocessor space
   localparam logic [4:0] IFR_RESP = 5'h00;
   localparam logic [4:0] IFR_CTRL = 5'h02;
   localparam logic [4:0] IFR_SAVE = 5'h04;
   localparam logic [4:0] IFR_REST = 5'h06;
   localparam logic [4:0] IFR_OPER = 5'h10;
   localparam logic [15:0] CTRL_ABORT = 16'h0001;
   localparam logic [15:0] CTRL_XACK = 16'h0002;
   localparam logic [7:0] FMT_EMPTY = 8'h00;
   localparam logic [7:0] FMT_INVALID = 8'h01;
   localparam logic [4:0] RSP_TAKE_PRE = 5'h1C;
   localparam logic [4:0] RSP_TAKE_MID = 5'h1D;
   localparam logic [4:0] RSP_TAKE_POST = 5'h1E;
   localparam logic [4:0] RSP_EMUL = 5'h1F;
   localparam int RSP_LSB = 8;
   localparam logic [3:0] OPC_LINE = 4'hF;
   localparam logic [2:0] OPC_RESTORE = 3'h5;
   localparam logic [31:0] FRAME_SKIP = 32'h0000_0004;
   localparam logic [31:0] LONG_STEP = 32'h0000_0004;
   // Software register byte offsets
   localparam logic [7:0] SW_CMD = 8'h00;
   localparam logic [7:0] SW_STAT = 8'h04;
   localparam logic [7:0] SW_OPC = 8'h08;
   localparam logic [7:0] SW_BASE = 8'h0C;
   localparam logic [7:0] SW_IDX = 8'h10;
   localparam logic [7:0] SW_PC = 8'h14;
   localparam logic [7:0] SW_EXT = 8'h18;
   localparam logic [7:0] SW_STATE = 8'h2C;
   localparam logic [7:0] SW_RESULT = 8'h30;
   localparam logic [7:0] SW_EA = 8'h34;
   localparam int CMD_RESTORE = 0;
   localparam int CMD_POLL = 1;
   localparam int CMD_SAVE = 2;
   localparam int SUP_BIT = 13;
   localparam logic [15:0] STAT_RST = 16'h0000;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_DECODE = 4'h1, S_HDR = 4'h3, S_WRRST = 4'h2,
      S_RDRST = 4'h6, S_CHECK = 4'h7, S_MEMRD = 4'h5, S_OPWR = 4'h4,
      S_DONE = 4'hC, S_ABORT = 4'hD, S_POLL = 4'hF, S_ACK = 4'hE,
      S_SAVE = 4'hA
   } crp_state_t;
   typedef enum logic [1:0] {RES_OK, RES_PRIV, RES_EMUL, RES_FMT} crp_result_t;
   typedef struct packed {
      logic ifr;
      logic we;
      logic word;
      logic [31:0] addr;
      logic [31:0] wdata;
   } crp_bus_t;
endpackage : crp_pkg
`default_nettype wire

// ==== src/crp_restore_port.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - decode selector from bits 11-9 and address mode from bits 5-0
// - five extension words are stored; only the first two feed the address computation
// - predecrement and invalid address encodings raise emulator exception
// - fetch header from memory, keep length, write header to restore register
// - read restore register back; valid header means copy bytes to operand
// - invalid code read back: write abort 0001 to control, then format error
// - empty or reset frame skips the operand transfer
// - user mode raises privilege violation with no register access on restore; poll and save commands skip the check
// - response register at 00 carries service requests, read on poll
// - control register at 02, bit 1 acknowledge, bit 0 abort
// - take-exception request answered with acknowledge bit write
// - abort on emulator response code from poll and on format error; failed supervisor check ends without abort
// - save register at 04; reading it starts a context store
// - restore register at 06; writing header starts a context reload
// - length not multiple of four is a format error with abort
// - frame moves as long words through operand register at 10
module crp_restore_port #(
   parameter int EXT_N = 5
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_bus_req,
   output var crp_pkg::crp_bus_t o_bus,
   input wire logic i_bus_ack,
   input wire logic [31:0] i_bus_rdata,
   output logic o_done,
   output logic o_exc,
   output logic [1:0] o_exc_kind
);
   crp_pkg::crp_state_t st;
   crp_pkg::crp_result_t result;
   logic [15:0] status_word;
   logic [15:0] opc;
   logic [31:0] base;
   logic [31:0] idx;
   logic [31:0] pc;
   logic [15:0] ext [EXT_N];
   logic [31:0] ea;
   logic [31:0] ea_q;
   logic ea_ok;
   logic opc_ok;
   logic [15:0] hdr;
   logic [15:0] rb;
   logic [7:0] remain;
   logic [31:0] mptr;
   logic [31:0] dbuf;
   logic acked;
   logic need_acc;
   logic cmd_wr;
   crp_pkg::crp_bus_t next_req;
   ////////////////////////////////////////////////////////////////////
   // Software registers
   assign cmd_wr = i_wr && (i_addr == crp_pkg::SW_CMD) && (st == crp_pkg::S_IDLE);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_word <= crp_pkg::STAT_RST;
         opc <= 16'h0000;
         base <= 32'h0000_0000;
         idx <= 32'h0000_0000;
         pc <= 32'h0000_0000;
      end else if (i_wr) begin
         if (i_addr == crp_pkg::SW_STAT) status_word <= i_wdata[15:0];
         if (i_addr == crp_pkg::SW_OPC) opc <= i_wdata[15:0];
         if (i_addr == crp_pkg::SW_BASE) base <= i_wdata;
         if (i_addr == crp_pkg::SW_IDX) idx <= i_wdata;
         if (i_addr == crp_pkg::SW_PC) pc <= i_wdata;
      end
   end
   for (genvar g = 0; g < EXT_N; g++) begin : g_ext
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            ext[g] <= 16'h0000;
         end else if (i_wr && i_addr == crp_pkg::SW_EXT + 8'(4 * g)) begin
            ext[g] <= i_wdata[15:0];
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            crp_pkg::SW_STAT: o_rdata <= {16'h0000, status_word};
            crp_pkg::SW_OPC: o_rdata <= {16'h0000, opc};
            crp_pkg::SW_BASE: o_rdata <= base;
            crp_pkg::SW_IDX: o_rdata <= idx;
            crp_pkg::SW_PC: o_rdata <= pc;
            crp_pkg::SW_STATE: o_rdata <= {24'h0, (st != crp_pkg::S_IDLE), result, 1'b0, st};
            crp_pkg::SW_RESULT: o_rdata <= {hdr, rb};
            crp_pkg::SW_EA: o_rdata <= ea_q;
            default: o_rdata <= (i_addr >= crp_pkg::SW_EXT && i_addr < crp_pkg::SW_STATE)
               ? {16'h0000, ext[3'(((i_addr - crp_pkg::SW_EXT) >> 2))]} : 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Opcode and address decode
   // line, type and address fields
   assign opc_ok = (opc[15:12] == crp_pkg::OPC_LINE) && (opc[8:6] == crp_pkg::OPC_RESTORE);
   always_comb begin
      ea_ok = 1'b1;
      ea = base;
      unique case (opc[5:3])
         3'd2, 3'd3: ea = base;
         3'd5: ea = base + {{16{ext[0][15]}}, ext[0]};
         3'd6: ea = base + idx + {{24{ext[0][7]}}, ext[0][7:0]};
         3'd7: begin
            unique case (opc[2:0])
               3'd0: ea = {{16{ext[0][15]}}, ext[0]};
               3'd1: ea = {ext[0], ext[1]};
               3'd2: ea = pc + 32'd2 + {{16{ext[0][15]}}, ext[0]};
               3'd3: ea = pc + 32'd2 + idx + {{24{ext[0][7]}}, ext[0][7:0]};
               default: ea_ok = 1'b0;
            endcase
         end
         default: ea_ok = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   // Bus access per state
   assign acked = o_bus_req && i_bus_ack;
   always_comb begin
      next_req = '0;
      need_acc = 1'b1;
      unique case (st)
         crp_pkg::S_HDR: begin
            next_req.word = 1'b1;
            next_req.addr = ea_q;
         end
         crp_pkg::S_WRRST: next_req = {3'b111, 24'h0, opc[11:9], crp_pkg::IFR_REST, 16'h0, hdr};
         crp_pkg::S_RDRST: next_req = {3'b101, 24'h0, opc[11:9], crp_pkg::IFR_REST, 32'h0};
         crp_pkg::S_MEMRD: next_req.addr = mptr;
         crp_pkg::S_OPWR: next_req = {3'b110, 24'h0, opc[11:9], crp_pkg::IFR_OPER, dbuf};
         crp_pkg::S_ABORT: next_req = {3'b111, 24'h0, opc[11:9], crp_pkg::IFR_CTRL,
                                        16'h0, crp_pkg::CTRL_ABORT};
         crp_pkg::S_POLL: next_req = {3'b101, 24'h0, opc[11:9], crp_pkg::IFR_RESP, 32'h0};
         crp_pkg::S_ACK: next_req = {3'b111, 24'h0, opc[11:9], crp_pkg::IFR_CTRL,
                                      16'h0, crp_pkg::CTRL_XACK};
         crp_pkg::S_SAVE: next_req = {3'b101, 24'h0, opc[11:9], crp_pkg::IFR_SAVE, 32'h0};
         default: need_acc = 1'b0;
      endcase
   end
   // Request held until ack; at least one idle cycle between accesses
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bus_req <= 1'b0;
         o_bus <= '0;
      end else if (acked) begin
         o_bus_req <= 1'b0;
      end else if (need_acc && !o_bus_req) begin
         o_bus_req <= 1'b1;
         o_bus <= next_req;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= crp_pkg::S_IDLE;
         result <= crp_pkg::RES_OK;
         ea_q <= 32'h0000_0000;
         hdr <= 16'h0000;
         rb <= 16'h0000;
         remain <= 8'h00;
         mptr <= 32'h0000_0000;
         dbuf <= 32'h0000_0000;
         o_done <= 1'b0;
         o_exc <= 1'b0;
         o_exc_kind <= 2'b00;
      end else begin
         o_done <= 1'b0;
         o_exc <= 1'b0;
         unique case (st)
            crp_pkg::S_IDLE: begin
               // Stale verdict must not leak into a save
               if (cmd_wr) result <= crp_pkg::RES_OK;
               if (cmd_wr && i_wdata[crp_pkg::CMD_RESTORE]) st <= crp_pkg::S_DECODE;
               else if (cmd_wr && i_wdata[crp_pkg::CMD_POLL]) st <= crp_pkg::S_POLL;
               else if (cmd_wr && i_wdata[crp_pkg::CMD_SAVE]) st <= crp_pkg::S_SAVE;
            end
            crp_pkg::S_DECODE: begin
               // user mode restore never reaches the coprocessor
               if (!status_word[crp_pkg::SUP_BIT]) begin
                  result <= crp_pkg::RES_PRIV;
                  st <= crp_pkg::S_DONE;
               end else if (!opc_ok || !ea_ok) begin
                  result <= crp_pkg::RES_EMUL;
                  st <= crp_pkg::S_DONE;
               end else begin
                  result <= crp_pkg::RES_OK;
                  ea_q <= ea;
                  st <= crp_pkg::S_HDR;
               end
            end
            crp_pkg::S_HDR: if (acked) begin
               hdr <= i_bus_rdata[15:0];
               remain <= i_bus_rdata[7:0];
               mptr <= ea_q + crp_pkg::FRAME_SKIP;
               st <= crp_pkg::S_WRRST;
            end
            crp_pkg::S_WRRST: if (acked) st <= crp_pkg::S_RDRST;
            crp_pkg::S_RDRST: if (acked) begin
               rb <= i_bus_rdata[15:0];
               st <= crp_pkg::S_CHECK;
            end
            crp_pkg::S_CHECK: begin
               if (rb[15:8] == crp_pkg::FMT_INVALID || remain[1:0] != 2'b00) begin
                  result <= crp_pkg::RES_FMT;
                  st <= crp_pkg::S_ABORT;
               end else if (rb[15:8] == crp_pkg::FMT_EMPTY || remain == 8'h00) begin
                  st <= crp_pkg::S_DONE;
               end else begin
                  st <= crp_pkg::S_MEMRD;
               end
            end
            crp_pkg::S_MEMRD: if (acked) begin
               dbuf <= i_bus_rdata;
               st <= crp_pkg::S_OPWR;
            end
            crp_pkg::S_OPWR: if (acked) begin
               mptr <= mptr + crp_pkg::LONG_STEP;
               remain <= remain - 8'h04;
               st <= (remain == 8'h04) ? crp_pkg::S_DONE : crp_pkg::S_MEMRD;
            end
            crp_pkg::S_ABORT: if (acked) st <= crp_pkg::S_DONE;
            crp_pkg::S_POLL: if (acked) begin
               rb <= i_bus_rdata[15:0];
               result <= crp_pkg::RES_OK;
               if (i_bus_rdata[crp_pkg::RSP_LSB +: 5] inside
                   {crp_pkg::RSP_TAKE_PRE, crp_pkg::RSP_TAKE_MID, crp_pkg::RSP_TAKE_POST}) begin
                  st <= crp_pkg::S_ACK;
               end else if (i_bus_rdata[crp_pkg::RSP_LSB +: 5] == crp_pkg::RSP_EMUL) begin
                  result <= crp_pkg::RES_EMUL;
                  st <= crp_pkg::S_ABORT;
               end else begin
                  st <= crp_pkg::S_DONE;
               end
            end
            crp_pkg::S_ACK: if (acked) st <= crp_pkg::S_DONE;
            crp_pkg::S_SAVE: if (acked) begin
               rb <= i_bus_rdata[15:0];
               st <= crp_pkg::S_DONE;
            end
            crp_pkg::S_DONE: begin
               o_done <= 1'b1;
               o_exc <= (result != crp_pkg::RES_OK);
               o_exc_kind <= result;
               st <= crp_pkg::S_IDLE;
            end
            default: st <= crp_pkg::S_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_priv;
      (st == crp_pkg::S_DECODE && !status_word[crp_pkg::SUP_BIT]) |=>
         !o_bus_req ##1 (o_exc && o_exc_kind == 2'd1 && !o_bus_req);
   endproperty
   a_priv: assert property (p_priv) else $error("privilege check failed");
   property p_emul;
      (st == crp_pkg::S_DECODE && status_word[crp_pkg::SUP_BIT] && !ea_ok) |=> ##1
         (o_exc && o_exc_kind == 2'd2);
   endproperty
   a_emul: assert property (p_emul) else $error("bad address not trapped");
   property p_hdr_first;
      $rose(o_bus_req) && st == crp_pkg::S_HDR |-> !o_bus.ifr && !o_bus.we && o_bus.addr == ea_q;
   endproperty
   a_hdr_first: assert property (p_hdr_first) else $error("header fetch wrong");
   property p_rest_wr;
      o_bus_req && o_bus.ifr && o_bus.we && o_bus.addr[4:0] == crp_pkg::IFR_REST |->
         o_bus.wdata[15:0] == hdr;
   endproperty
   a_rest_wr: assert property (p_rest_wr) else $error("restore write not header");
   property p_invalid;
      (st == crp_pkg::S_CHECK && rb[15:8] == crp_pkg::FMT_INVALID) |=> ##1
         (o_bus_req && o_bus.addr[4:0] == crp_pkg::IFR_CTRL && o_bus.wdata[15:0] == 16'h0001);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid format not aborted");
   property p_len;
      (st == crp_pkg::S_CHECK && remain[1:0] != 2'b00) |=> st == crp_pkg::S_ABORT;
   endproperty
   a_len: assert property (p_len) else $error("odd length accepted");
   property p_empty;
      (st == crp_pkg::S_CHECK && rb[15:8] == crp_pkg::FMT_EMPTY && remain[1:0] == 2'b00)
         |=> st == crp_pkg::S_DONE ##1 (o_done && !o_exc);
   endproperty
   a_empty: assert property (p_empty) else $error("empty frame transferred");
   property p_oper;
      o_bus_req && st == crp_pkg::S_OPWR |-> o_bus.ifr && o_bus.we && !o_bus.word &&
         o_bus.addr[4:0] == crp_pkg::IFR_OPER && o_bus.wdata == dbuf;
   endproperty
   a_oper: assert property (p_oper) else $error("operand write malformed");
   property p_ack;
      o_bus_req && st == crp_pkg::S_ACK |-> o_bus.we && o_bus.wdata[15:0] == 16'h0002;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge malformed");
   property p_hold;
      o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped early");
   c_xfer: cover property (st == crp_pkg::S_OPWR && acked ##[1:20] o_done && !o_exc);
   c_fmt: cover property (st == crp_pkg::S_ABORT ##[1:20] o_exc && o_exc_kind == 2'd3);
   c_priv: cover property (o_exc && o_exc_kind == 2'd1);
   c_ack: cover property (st == crp_pkg::S_ACK && acked);
endmodule : crp_restore_port
`default_nettype wire

// ==== testbench/crp_cop_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module crp_cop_model #(
   parameter logic [15:0] SAVE_WORD = 16'h2408
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire crp_pkg::crp_bus_t i_bus,
   input wire logic [15:0] i_hdr,
   input wire logic [15:0] i_resp,
   input wire logic i_reject,
   input wire logic i_slow,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [1:0] wait_c;
   logic [15:0] rest_q;
   logic [15:0] ctrl_last;
   logic [31:0] op_last;
   logic [31:0] rd_val;
   logic [2:0] sel_last;
   int op_cnt;
   int ctrl_cnt;
   int acc_cnt;
   ////////////////////////////////////////////////////////////////
   // register read map
   always_comb begin
      rd_val = 32'h0000_0000;
      if (!i_bus.ifr) begin
         rd_val = i_bus.word ? {16'h0000, i_hdr} : (i_bus.addr ^ 32'hC3C3_0000);
      end else if (i_bus.addr[4:0] == crp_pkg::IFR_RESP) begin
         rd_val = {16'h0000, i_resp};
      end else if (i_bus.addr[4:0] == crp_pkg::IFR_SAVE) begin
         rd_val = {16'h0000, SAVE_WORD};
      end else if (i_bus.addr[4:0] == crp_pkg::IFR_REST) begin
         rd_val = {16'h0000, rest_q};
      end
   end
   ////////////////////////////////////////////////////////////////
   // Released data lines toggle so stale data never passes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ack <= 1'b0;
         o_rdata <= 32'h0000_0000;
         wait_c <= 2'h0;
         rest_q <= 16'h0000;
         ctrl_last <= 16'h0000;
         op_last <= 32'h0000_0000;
         sel_last <= 3'h0;
         op_cnt <= 0;
         ctrl_cnt <= 0;
         acc_cnt <= 0;
      end else if (i_req && !o_ack && (!i_slow || wait_c == 2'h3)) begin
         o_ack <= 1'b1;
         wait_c <= 2'h0;
         acc_cnt <= acc_cnt + 1;
         o_rdata <= rd_val;
         if (i_bus.ifr) begin
            sel_last <= i_bus.addr[7:5];
         end
         if (i_bus.ifr && i_bus.we) begin
            case (i_bus.addr[4:0])
               crp_pkg::IFR_CTRL: begin
                  ctrl_last <= {14'h0000, i_bus.wdata[1:0]};
                  ctrl_cnt <= ctrl_cnt + 1;
               end
               crp_pkg::IFR_REST: begin
                  rest_q <= i_reject ? {crp_pkg::FMT_INVALID, 8'h00} : i_bus.wdata[15:0];
               end
               crp_pkg::IFR_OPER: begin
                  op_last <= i_bus.wdata;
                  op_cnt <= op_cnt + 1;
               end
               default: begin
               end
            endcase
         end
      end else begin
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata;
         wait_c <= (i_req && !o_ack) ? wait_c + 2'h1 : 2'h0;
      end
   end
endmodule : crp_cop_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clk;
   logic i_rst_n;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [31:0] o_rdata;
   logic o_bus_req;
   crp_pkg::crp_bus_t o_bus;
   logic i_bus_ack;
   logic [31:0] i_bus_rdata;
   logic o_done;
   logic o_exc;
   logic [1:0] o_exc_kind;
   logic [15:0] hdr;
   logic [15:0] resp;
   logic reject;
   logic slow;
   logic [31:0] rv;
   logic [4:0] codes [5];
   int err_total;
   int comparisons;
   int o0;
   int c0;
   int a0;
   ////////////////////////////////////////////////////////////////
   crp_restore_port #(.EXT_N(5)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bus_req(o_bus_req),
      .o_bus(o_bus), .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata), .o_done(o_done),
      .o_exc(o_exc), .o_exc_kind(o_exc_kind));
   crp_cop_model cop_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_bus_req), .i_bus(o_bus),
      .i_hdr(hdr), .i_resp(resp), .i_reject(reject), .i_slow(slow), .o_ack(i_bus_ack),
      .o_rdata(i_bus_rdata));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd
   task automatic run(input logic [31:0] cmd, input logic [1:0] kind);
      int n;
      o0 = cop_u.op_cnt;
      c0 = cop_u.ctrl_cnt;
      a0 = cop_u.acc_cnt;
      wr(crp_pkg::SW_CMD, cmd);
      n = 0;
      while (o_done !== 1'b1 && n < 300) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk(n < 300, 1);
      chk(o_exc, kind != 2'd0);
      chk(o_exc_kind, kind);
      $display("test cmd %h kind %0d done", cmd, kind);
   endtask : run
   task automatic t_rest(input logic [15:0] h, input logic rj, input logic [1:0] kind,
      input int ops);
      hdr = h;
      reject = rj;
      run(32'h0000_0001, kind);
      chk(cop_u.op_cnt - o0, ops);
      chk(cop_u.ctrl_cnt - c0, kind == 2'd3);
      if (kind == 2'd3) begin
         chk(cop_u.ctrl_last, crp_pkg::CTRL_ABORT);
      end else begin
         chk(cop_u.acc_cnt - a0, 3 + 2 * ops);
         rd(crp_pkg::SW_RESULT, rv);
         chk(rv, {h, h});
      end
   endtask : t_rest
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////
   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      test_done();
   end
   initial begin
      codes = '{crp_pkg::RSP_TAKE_PRE, crp_pkg::RSP_TAKE_MID, crp_pkg::RSP_TAKE_POST,
         crp_pkg::RSP_EMUL, 5'h05};
      i_rst_n = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      hdr = 16'h0000;
      resp = 16'h0000;
      reject = 1'b0;
      slow = 1'b0;
      err_total = 0;
      comparisons = 0;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(crp_pkg::SW_STAT, rv);
      chk(rv, 32'h0000_0000);
      wr(crp_pkg::SW_OPC, 32'h0000_F350);
      wr(crp_pkg::SW_BASE, 32'h0000_0100);
      rd(crp_pkg::SW_OPC, rv);
      chk(rv, 32'h0000_F350);
      rd(8'h40, rv);
      chk(rv, 32'h0000_0000);
      run(32'h0000_0001, 2'd1);
      chk(cop_u.acc_cnt - a0, 0);
      wr(crp_pkg::SW_STAT, 32'h0000_2000);
      t_rest(16'h2008, 1'b0, 2'd0, 2);
      chk(cop_u.op_last, 32'hC3C3_0108);
      chk(cop_u.sel_last, 3'h1);
      rd(crp_pkg::SW_EA, rv);
      chk(rv, 32'h0000_0100);
      slow = 1'b1;
      t_rest(16'h2004, 1'b0, 2'd0, 1);
      t_rest(16'h2008, 1'b1, 2'd3, 0);
      t_rest(16'h2006, 1'b0, 2'd3, 0);
      t_rest(16'h0000, 1'b0, 2'd0, 0);
      slow = 1'b0;
      wr(crp_pkg::SW_OPC, 32'h0000_F360);
      run(32'h0000_0001, 2'd2);
      // Displacement, brief index and absolute long address forms
      wr(crp_pkg::SW_EXT, 32'h0000_FFF0);
      wr(crp_pkg::SW_EXT + 8'h04, 32'h0000_0200);
      wr(crp_pkg::SW_IDX, 32'h0000_0020);
      wr(crp_pkg::SW_OPC, 32'h0000_F368);
      t_rest(16'h0000, 1'b0, 2'd0, 0);
      rd(crp_pkg::SW_EA, rv);
      chk(rv, 32'h0000_00F0);
      wr(crp_pkg::SW_OPC, 32'h0000_F370);
      t_rest(16'h0000, 1'b0, 2'd0, 0);
      rd(crp_pkg::SW_EA, rv);
      chk(rv, 32'h0000_0110);
      wr(crp_pkg::SW_OPC, 32'h0000_F379);
      t_rest(16'h0000, 1'b0, 2'd0, 0);
      rd(crp_pkg::SW_EA, rv);
      chk(rv, 32'hFFF0_0200);
      wr(crp_pkg::SW_OPC, 32'h0000_F350);
      for (int k = 0; k < 5; k++) begin
         resp = {3'b000, codes[k], 8'h00};
         run(32'h0000_0002, (k == 3) ? 2'd2 : 2'd0);
         chk(cop_u.ctrl_cnt - c0, k < 4);
         if (k < 4) begin
            chk(cop_u.ctrl_last, (k == 3) ? crp_pkg::CTRL_ABORT : crp_pkg::CTRL_XACK);
         end
      end
      run(32'h0000_0004, 2'd0);
      chk(cop_u.acc_cnt - a0, 1);
      rd(crp_pkg::SW_RESULT, rv);
      chk(rv[15:0], 16'h2408);
      test_done();
   end
endmodule : tb
`default_nettype wire
